// ===== ascs_map.vh
/*
 * constants for the sample and convert sequencer: register offsets,
 * field positions, reset values and timing counts.
 * assumes inclusion by bare name from the sequencer module.
 */
`ifndef ASCS_MAP_VH
`define ASCS_MAP_VH

// register word addresses
`define ASCS_CTRL_ADDR      8'h00
`define ASCS_STATUS_ADDR    8'h01
`define ASCS_FLAGS_ADDR     8'h02
`define ASCS_ENTRY_BASE     8'h40
`define ASCS_RESULT_BASE    8'h80

// control register fields
`define ASCS_CTRL_ENABLE    0
`define ASCS_CTRL_SWSTART   1
`define ASCS_CTRL_METHOD    2
`define ASCS_CTRL_INVERT    3
`define ASCS_CTRL_FORMAT    4
`define ASCS_CTRL_MODE_LO   5
`define ASCS_CTRL_RES_LO    7
`define ASCS_CTRL_SRC_LO    9
`define ASCS_CTRL_START_LO  12
`define ASCS_CTRL_SHTA_LO   17
`define ASCS_CTRL_SHTB_LO   21
`define ASCS_CTRL_RESET     32'h0000_0000

// entry control fields
`define ASCS_ENT_CHAN_LO    0
`define ASCS_ENT_DIFF       5
`define ASCS_ENT_EOS        6
`define ASCS_ENT_REF_LO     8
`define ASCS_ENT_RESET      12'h000

// conversion cycles per resolution
`define ASCS_CONV_8         5'd10
`define ASCS_CONV_10        5'd12
`define ASCS_CONV_12        5'd14

// differential offsets
`define ASCS_OFS_8          12'h080
`define ASCS_OFS_10         12'h200
`define ASCS_OFS_12         12'h800

// resolution and mode codes
`define ASCS_RES_8          2'b00
`define ASCS_RES_10         2'b01
`define ASCS_RES_12         2'b10
`define ASCS_MODE_SINGLE    2'b00
`define ASCS_MODE_SEQ       2'b01
`define ASCS_MODE_RPT_SINGLE 2'b10
`define ASCS_MODE_RPT_SEQ   2'b11

`endif

// ===== ascs_sequencer.v
/*
 * sample and convert sequencer: trigger select and inversion, extended
 * and pulse sampling, conversion timing, entry walk and result format.
 * assumes the analog core holds a 12 bit code on convCode in the ST_DONE cycle
 * and that all inputs are synchronous to core_clk (the conversion clock).
 */
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`include "ascs_map.vh"

// Function
// - rising trigger edge starts sample and convert
// - source select: software bit or seven inputs
// - conversion takes 10, 12, 14 cycles
// - polarity bit inverts selected trigger
// - extended mode: sampling follows trigger, sync+1
// - odd reference code means buffer in use
// - pulse mode: timer holds sampling through settling
// - sample time in steps of four cycles
// - time field A for entries 8-23
// - 32 results, each with control entry
// - pointer wraps 31 to 0 without end
// - start entry; sequence advances to end bit
// - result write sets its entry flag
// - format 0: right justified unsigned
// - differential unsigned adds half-scale offset
// - format 1: left justified two's complement
// - resolution codes 00, 01, 10 decoded
// - mode codes: single, sequence, repeats decoded
// - single mode: software retriggers, else re-enable
// - sequence stops at end bit; software retriggers, else rearm
// - no conversion unless enable bit set
module ascs_sequencer #(
	parameter ENTRIES   = 32,
	parameter SETTLE_CY = 8
) (
	// clock and reset
	input  wire        core_clk,
	input  wire        rst_n,
	// register port
	input  wire [7:0]  regAddr,
	input  wire [31:0] regWdata,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [31:0] regRdata_r,
	// hardware trigger sources
	input  wire [6:0]  hwTrigger,
	// analog core
	input  wire        refSettled,
	input  wire [11:0] convCode,
	output reg         samplingActive_r,
	output reg         convStart_r,
	output reg  [4:0]  coreChannel_r,
	output reg  [3:0]  coreRef_r,
	output reg         coreDiff_r,
	output reg         refBufOn_r,
	output reg         refReadyFlag_r,
	output reg         busy_r
);
	localparam ST_IDLE = 5'b00001;
	localparam ST_SAMP = 5'b00010;
	localparam ST_SYNC = 5'b00100;
	localparam ST_CONV = 5'b01000;
	localparam ST_DONE = 5'b10000;

	reg [31:0] ctrl_r;
	reg [11:0] entry_r [0:ENTRIES-1];
	reg [15:0] result_r [0:ENTRIES-1];
	reg [31:0] flags_r;
	reg [4:0]  state_r;
	reg [4:0]  ptr_r;
	reg [9:0]  cnt_r;
	reg        trigPrev_r;
	reg        armed_r;
	reg        settled_r;
	reg        swStart_r;
	integer    i;

	wire       enable   = ctrl_r[`ASCS_CTRL_ENABLE];
	wire       method   = ctrl_r[`ASCS_CTRL_METHOD];
	wire       invert   = ctrl_r[`ASCS_CTRL_INVERT];
	wire       fmt      = ctrl_r[`ASCS_CTRL_FORMAT];
	wire [1:0] mode     = ctrl_r[`ASCS_CTRL_MODE_LO +: 2];
	wire [1:0] res      = ctrl_r[`ASCS_CTRL_RES_LO +: 2];
	wire [2:0] srcSel   = ctrl_r[`ASCS_CTRL_SRC_LO +: 3];
	wire [4:0] startSel = ctrl_r[`ASCS_CTRL_START_LO +: 5];
	wire [3:0] shtA     = ctrl_r[`ASCS_CTRL_SHTA_LO +: 4];
	wire [3:0] shtB     = ctrl_r[`ASCS_CTRL_SHTB_LO +: 4];

	// trigger select and polarity
	wire rawTrig = (srcSel == 3'd0) ? swStart_r : hwTrigger[srcSel - 3'd1];
	wire trig    = rawTrig ^ invert;
	wire trigRise = trig & ~trigPrev_r;

	wire [11:0] curEntry = entry_r[ptr_r];
	wire        curEos   = curEntry[`ASCS_ENT_EOS];
	wire        curDiff  = curEntry[`ASCS_ENT_DIFF];
	wire        bufUse   = curEntry[`ASCS_ENT_REF_LO];
	wire        seqMode  = mode[0];
	wire        rptMode  = mode[1];

	function [4:0] conv_cycles;
		input [1:0] r;
		begin
			case (r)
				`ASCS_RES_8:  conv_cycles = `ASCS_CONV_8;
				`ASCS_RES_10: conv_cycles = `ASCS_CONV_10;
				default:      conv_cycles = `ASCS_CONV_12;
			endcase
		end
	endfunction

	// four cycles per step; code 0 still gives one step
	function [9:0] sample_cycles;
		input [4:0] p;
		input [3:0] a;
		input [3:0] b;
		reg   [3:0] s;
		begin
			s = ((p >= 5'd8) && (p <= 5'd23)) ? a : b;
			sample_cycles = {4'h0, s, 2'b00} + 10'd4;
		end
	endfunction

	function [15:0] format_result;
		input [11:0] c;
		input [1:0]  r;
		input        d;
		input        f;
		reg   [11:0] u;
		reg   [11:0] ofs;
		reg   [11:0] m;
		begin
			case (r)
				`ASCS_RES_8:  begin m = 12'h0ff; ofs = `ASCS_OFS_8;  end
				`ASCS_RES_10: begin m = 12'h3ff; ofs = `ASCS_OFS_10; end
				default:      begin m = 12'hfff; ofs = `ASCS_OFS_12; end
			endcase
			// core codes differential as signed; unsigned view adds offset
			u = d ? ((c + ofs) & m) : (c & m);
			if (!f) begin
				format_result = {4'h0, u};
			end else begin
				// two's complement: flip msb of the unsigned value, justify left
				case (r)
					`ASCS_RES_8:  format_result = {~u[7],  u[6:0], 8'h00};
					`ASCS_RES_10: format_result = {~u[9],  u[8:0], 6'h00};
					default:      format_result = {~u[11], u[10:0], 4'h0};
				endcase
			end
		end
	endfunction

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r           <= `ASCS_CTRL_RESET;
			flags_r          <= 32'h0000_0000;
			state_r          <= ST_IDLE;
			ptr_r            <= 5'h00;
			cnt_r            <= 10'h000;
			trigPrev_r       <= 1'b0;
			armed_r          <= 1'b0;
			settled_r        <= 1'b0;
			swStart_r        <= 1'b0;
			regRdata_r       <= 32'h0000_0000;
			samplingActive_r <= 1'b0;
			convStart_r      <= 1'b0;
			coreChannel_r    <= 5'h00;
			coreRef_r        <= 4'h0;
			coreDiff_r       <= 1'b0;
			refBufOn_r       <= 1'b0;
			refReadyFlag_r   <= 1'b0;
			busy_r           <= 1'b0;
			for (i = 0; i < ENTRIES; i = i + 1) begin
				entry_r[i]  <= `ASCS_ENT_RESET;
				result_r[i] <= 16'h0000;
			end
		end else begin
			trigPrev_r  <= trig;
			convStart_r <= 1'b0;
			// software start bit self-clears after one cycle
			swStart_r   <= 1'b0;

			// register writes; config is meant to change only while disabled
			if (regWr) begin
				if (regAddr == `ASCS_CTRL_ADDR) begin
					ctrl_r <= {regWdata[31:2], 1'b0, regWdata[0]};
					swStart_r <= regWdata[`ASCS_CTRL_SWSTART];
					// re-enable after disable rearms the trigger
					if (regWdata[`ASCS_CTRL_ENABLE] && !enable)
						armed_r <= 1'b1;
					if (!regWdata[`ASCS_CTRL_ENABLE])
						armed_r <= 1'b0;
				end
				if ((regAddr & 8'hc0) == `ASCS_ENTRY_BASE)
					entry_r[regAddr[4:0]] <= regWdata[11:0];
			end

			// reads: result read clears its flag unless set now
			regRdata_r <= 32'h0000_0000;
			if (regRd) begin
				if (regAddr == `ASCS_CTRL_ADDR)
					regRdata_r <= ctrl_r;
				else if (regAddr == `ASCS_STATUS_ADDR)
					regRdata_r <= {21'h0, ptr_r, state_r, busy_r};
				else if (regAddr == `ASCS_FLAGS_ADDR)
					regRdata_r <= flags_r;
				else if ((regAddr & 8'hc0) == `ASCS_ENTRY_BASE)
					regRdata_r <= {20'h0, entry_r[regAddr[4:0]]};
				else if ((regAddr & 8'hc0) == `ASCS_RESULT_BASE)
					regRdata_r <= {16'h0, result_r[regAddr[4:0]]};
			end
			if (regRd && ((regAddr & 8'hc0) == `ASCS_RESULT_BASE)
			    && !((state_r == ST_DONE) && (ptr_r == regAddr[4:0])))
				flags_r[regAddr[4:0]] <= 1'b0;

			coreChannel_r <= curEntry[`ASCS_ENT_CHAN_LO +: 5];
			coreRef_r     <= curEntry[`ASCS_ENT_REF_LO +: 4];
			coreDiff_r    <= curDiff;

			case (state_r)
				ST_IDLE: begin
					// busy stays up between entries of a running sequence
					if (!enable)
						busy_r <= 1'b0;
					if (!busy_r)
						ptr_r <= startSel;
					if (enable && trigRise && (armed_r || srcSel == 3'd0)) begin
						state_r          <= ST_SAMP;
						samplingActive_r <= 1'b1;
						busy_r           <= 1'b1;
						refBufOn_r       <= bufUse;
						settled_r        <= ~bufUse;
						// without buffer the sample interval is loaded at once
						cnt_r            <= bufUse ? SETTLE_CY[9:0] :
						                    sample_cycles(busy_r ? ptr_r : startSel, shtA, shtB);
						armed_r          <= 1'b0;
					end
				end
				ST_SAMP: begin
					if (!settled_r) begin
						// settling; in extended mode ready flag only while trigger is asserted
						if (cnt_r != 10'h000)
							cnt_r <= cnt_r - 10'd1;
						// pulse mode needs no held trigger while settling
						else if (refSettled && (trig || method)) begin
							settled_r      <= 1'b1;
							refReadyFlag_r <= 1'b1;
							cnt_r <= sample_cycles(ptr_r, shtA, shtB);
						end
					end else if (!method) begin
						if (!trig) begin
							samplingActive_r <= 1'b0;
							state_r          <= ST_SYNC;
						end
					end else if (cnt_r > 10'd1) begin
						cnt_r <= cnt_r - 10'd1;
					end else begin
						samplingActive_r <= 1'b0;
						state_r          <= ST_SYNC;
					end
				end
				ST_SYNC: begin
					// one further cycle after sync, then conversion runs
					refReadyFlag_r <= 1'b0;
					convStart_r    <= 1'b1;
					cnt_r          <= {5'h00, conv_cycles(res)};
					state_r        <= ST_CONV;
				end
				ST_CONV: begin
					if (cnt_r > 10'd1)
						cnt_r <= cnt_r - 10'd1;
					else
						state_r <= ST_DONE;
				end
				ST_DONE: begin
					result_r[ptr_r] <= format_result(convCode, res, curDiff, fmt);
					flags_r[ptr_r]  <= 1'b1;
					state_r         <= ST_IDLE;
					if (seqMode && !curEos) begin
						ptr_r  <= ptr_r + 5'd1;
						busy_r <= 1'b1;
						armed_r <= 1'b1;
					end else begin
						// end of sequence or single: stop or rearm
						busy_r  <= 1'b0;
						armed_r <= rptMode & enable;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule

// ===== ascs_sequencer_checker.sv
/* port assertions for the sample and convert sequencer.
   assumes the bind below onto ascs_sequencer, one clock. */
module ascs_sequencer_checker (
	// clock and reset
	input wire        core_clk,
	input wire        rst_n,
	// register port
	input wire        regRd,
	input wire [31:0] regRdata_r,
	// core side
	input wire        refSettled,
	input wire        samplingActive_r,
	input wire        convStart_r,
	input wire        refBufOn_r,
	input wire        refReadyFlag_r,
	input wire        busy_r
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_rd_quiet; !$past(regRd) |-> regRdata_r == 32'h0; endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
	property p_fall_start; $fell(samplingActive_r) && $past(rst_n) |-> ##[0:2] convStart_r; endproperty
	a_fall_start: assert property (p_fall_start) else $error("no start after window");
	property p_conv_min; convStart_r |=> !samplingActive_r [*8]; endproperty
	a_conv_min: assert property (p_conv_min) else $error("sampling during conversion");
	property p_start_busy; convStart_r |-> !samplingActive_r && busy_r; endproperty
	a_start_busy: assert property (p_start_busy) else $error("start outside busy");
	property p_samp_busy; samplingActive_r |-> busy_r; endproperty
	a_samp_busy: assert property (p_samp_busy) else $error("sampling while idle");
	property p_busy_rise; $rose(busy_r) && $past(rst_n) |-> samplingActive_r; endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy without sampling");
	property p_rdy_buf; refReadyFlag_r |-> busy_r && refBufOn_r; endproperty
	a_rdy_buf: assert property (p_rdy_buf) else $error("ready without buffer");
	property p_rdy_cause;
		$rose(refReadyFlag_r) && $past(rst_n) |-> $past(refSettled) && $past(samplingActive_r);
	endproperty
	a_rdy_cause: assert property (p_rdy_cause) else $error("ready without settle");
	c_start: cover property (convStart_r);
	c_ready: cover property ($rose(refReadyFlag_r));
	c_done: cover property ($fell(busy_r));
endmodule

bind ascs_sequencer ascs_sequencer_checker u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .regRd(regRd), .regRdata_r(regRdata_r),
	.refSettled(refSettled), .samplingActive_r(samplingActive_r),
	.convStart_r(convStart_r), .refBufOn_r(refBufOn_r),
	.refReadyFlag_r(refReadyFlag_r), .busy_r(busy_r)
);

// ===== ascs_core_model.sv
/* analog core model: delivers a code and settles the buffer.
   assumes the sequencer ports on core_clk. */
module ascs_core_model (
	// clock and reset
	input  wire         core_clk,
	input  wire         rst_n,
	// from sequencer; codeVal from the bench
	input  wire         samplingActive_r,
	input  wire         convStart_r,
	input  wire         refBufOn_r,
	input  wire  [11:0] codeVal,
	// to sequencer
	output logic        refSettled,
	output logic [11:0] convCode
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] hold_r;
	logic [1:0] settle_r;
	// outside a conversion the lines show the inverse, so no stale match
	assign convCode   = (hold_r != 5'h0) ? codeVal : ~codeVal;
	assign refSettled = &settle_r;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_r   <= 5'h0;
			settle_r <= 2'h0;
		end else begin
			hold_r   <= convStart_r ? 5'h10 : hold_r - {4'h0, hold_r != 5'h0};
			// settles only while sampling with the buffer on
			settle_r <= (samplingActive_r && refBufOn_r) ? settle_r + {1'b0, ~&settle_r} : 2'h0;
		end
	end
endmodule

// ===== adc_sample_convert_sequencer_tb.sv
/* self-checking bench for ascs_sequencer through its register port.
   assumes ascs_core_model as the analog core. */
`include "ascs_map.vh"
`define CHK(n,x,g) begin checked++; if ((x) !== (g)) begin err_total++; \
	$display("MISMATCH %s exp %0h got %0h", n, x, g); end end
module adc_sample_convert_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rst_n = 0, regWr = 0, regRd = 0, inv = 0;
	logic [7:0] regAddr = 0;
	logic [31:0] regWdata = 0, regRdata_r, rdv, ctrlV, e;
	logic [6:0] hwTrigger = 0;
	logic [11:0] codeVal = 12'h9a3, convCode;
	logic refSettled, samplingActive_r, convStart_r, refBufOn_r, busy_r;
	logic [4:0] coreChannel_r;
	int err_total = 0, checked = 0, runLen = 0, lastLen = 0, cvLen = 0, nStarts = 0, tick = 0;
	int n0, i, cl[3];
	initial forever #10 core_clk = ~core_clk;
	ascs_sequencer #(.SETTLE_CY(2)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata_r(regRdata_r), .hwTrigger(hwTrigger), .refSettled(refSettled),
		.convCode(convCode), .samplingActive_r(samplingActive_r), .convStart_r(convStart_r),
		.coreChannel_r(coreChannel_r), .coreRef_r(), .coreDiff_r(), .refBufOn_r(refBufOn_r),
		.refReadyFlag_r(), .busy_r(busy_r));
	ascs_core_model u_core (.core_clk(core_clk), .rst_n(rst_n), .samplingActive_r(samplingActive_r),
		.convStart_r(convStart_r), .refBufOn_r(refBufOn_r), .codeVal(codeVal),
		.refSettled(refSettled), .convCode(convCode));
	task end_sim;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge core_clk) begin
		tick <= tick + 1;
		if (tick == 20000) begin err_total++; end_sim; end
		if (samplingActive_r === 1'b1) runLen <= runLen + 1;
		else if (runLen != 0) begin lastLen <= runLen; runLen <= 0; end
		if (convStart_r === 1'b1) begin nStarts <= nStarts + 1; cvLen <= 0; end
		else if (busy_r === 1'b1) cvLen <= cvLen + 1;
	end
	task wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a; regWdata <= d; regWr <= 1; @(posedge core_clk);
		regWr <= 0; @(posedge core_clk);
	endtask
	task chkr(input string n, input logic [7:0] a, input logic [31:0] x);
		regAddr <= a; regRd <= 1; @(posedge core_clk);
		regRd <= 0; #1 rdv = regRdata_r; @(posedge core_clk);
		`CHK(n, x, rdv)
	endtask
	// enable dropped first: config may only change while disabled
	task setc(input logic [31:0] v);
		ctrlV = v; wr(`ASCS_CTRL_ADDR, v & ~32'h1); wr(`ASCS_CTRL_ADDR, v);
	endtask
	task fire(input int s, input int h);
		n0 = nStarts;
		if (s == 0) wr(`ASCS_CTRL_ADDR, ctrlV | 32'h2);
		else begin
			hwTrigger[s-1] <= !inv; repeat (h) @(posedge core_clk);
			hwTrigger[s-1] <= inv; @(posedge core_clk);
		end
		for (i = 0; i < 60 && nStarts == n0; i++) @(posedge core_clk);
		repeat (18) @(posedge core_clk);
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1; @(posedge core_clk);
		chkr("ctrl", `ASCS_CTRL_ADDR, `ASCS_CTRL_RESET);
		chkr("unmapped", 8'h03, 32'h0);
		wr(`ASCS_ENTRY_BASE, 32'h45);
		for (int r = 0; r < 3; r++) begin
			setc(32'h5 | r << 7); fire(0, 0); `CHK("samp", 4, lastLen)
			cl[r] = cvLen;
		end
		`CHK("c10", 2, cl[1] - cl[0])
		`CHK("c12", 4, cl[2] - cl[0])
		`CHK("chan", 5'h05, coreChannel_r)
		chkr("flag", `ASCS_FLAGS_ADDR, 32'h1);
		for (int k = 0; k < 4; k++) begin
			wr(`ASCS_ENTRY_BASE, 32'h45 | k[0] << 5); setc(32'h105 | k[1] << 4); fire(0, 0);
			e = {20'h0, k[0] ? codeVal + 12'h800 : codeVal};
			if (k[1]) e = {16'h0, e[11:0] ^ 12'h800, 4'h0};
			chkr("fmt", `ASCS_RESULT_BASE, e);
		end
		chkr("flagclr", `ASCS_FLAGS_ADDR, 32'h0);
		wr(`ASCS_ENTRY_BASE + 23, 0); wr(`ASCS_ENTRY_BASE + 24, 32'h40);
		wr(`ASCS_ENTRY_BASE + 31, 0); wr(`ASCS_ENTRY_BASE, 32'h40);
		for (int s = 0; s < 2; s++) begin
			setc(32'h20325 | (s ? 31 : 23) << 12);
			fire(1, 1); `CHK("sa", s ? 4 : 8, lastLen)
			fire(1, 1); `CHK("sb", 4, lastLen)
			fire(1, 1); `CHK("stop", n0, nStarts)
		end
		chkr("seqf", `ASCS_FLAGS_ADDR, 32'h8180_0001);
		setc(32'h705);
		fire(1, 1); `CHK("src", n0, nStarts)
		fire(3, 1); `CHK("src3", n0 + 1, nStarts)
		fire(3, 1); `CHK("rearm", n0, nStarts)
		for (int m = 2; m < 4; m++) begin
			setc(32'h705 | m << 5); fire(3, 1); fire(3, 1); `CHK("rpt", n0 + 1, nStarts)
		end
		inv = 1; hwTrigger <= 7'h7f; setc(32'h70d);
		fire(3, 1); `CHK("inv", n0 + 1, nStarts)
		inv = 0; hwTrigger <= 7'h0; setc(32'h701);
		fire(3, 6); `CHK("ext", 1, lastLen >= 6 && lastLen <= 8)
		wr(`ASCS_ENTRY_BASE, 32'h140); setc(32'h105);
		fire(0, 0); `CHK("buf", 1, lastLen > 6)
		n0 = nStarts; wr(`ASCS_CTRL_ADDR, 32'h106); repeat (30) @(posedge core_clk);
		`CHK("off", n0, nStarts)
		end_sim;
	end
endmodule
